// file: dv/tb_top.sv
// Self-checking bench for the key-exchange handler
`timescale 1ns/10ps
`default_nettype none
module tb_top import tkx_pkg::*;;
	logic clk_sys, rst, rxValid, rxFirst, rxReady, fieldValid;
	logic [1:0] rxType, fieldKind, capCipher, cryptoKind;
	logic [7:0] rxData, fieldIndex, fieldData, cryptoIndex, cryptoByte, txData, nvCounter;
	logic [7:0] cloneCounter;
	logic capPubKey, capHash, capNonce, keyUpdate, keySlot, firstExchange, duplicateDrop;
	logic txValid, txLast, txReady, nvLoad, nvCookieSeq, nvCounterSeq, connectConfirm, nvWrite;
	logic cookieSeq, counterSeq, slow, clr;
	logic [159:0] newCookie, authCookie, nvCookie, cookie;
	logic [7:0] req [0:205];
	int bad_count, comparisons, fvCnt, dupCnt, keyCnt, nvCnt, k0, f0;
	logic [1:0] lastKind;
	logic [7:0] lastIdx, lastData;
	logic [31:0] offers [0:2] = '{32'hff010301, 32'h01010201, 32'h01010101};
	logic [4:0] caps [0:2] = '{5'b11111, 5'b10010, 5'b11011};
	logic [31:0] picks [0:2] = '{32'h01010201, 32'h01000000, 32'h01010101};

	assign cryptoByte = {cryptoKind, cryptoIndex[5:0]};

	tkx_key_exchange i_dut (.clk_sys, .rst, .rxValid, .rxFirst, .rxType, .rxData, .rxReady,
		.fieldValid, .fieldKind, .fieldIndex, .fieldData, .capPubKey, .capHash, .capCipher,
		.capNonce, .cryptoKind, .cryptoIndex, .cryptoByte, .newCookie, .authCookie, .keyUpdate,
		.keySlot, .firstExchange, .duplicateDrop, .txValid, .txData, .txLast, .txReady,
		.nvLoad, .nvCookie, .nvCookieSeq, .nvCounter, .nvCounterSeq, .connectConfirm, .nvWrite,
		.cookie, .cookieSeq, .cloneCounter, .counterSeq);

	tkx_net_model i_net (.clk_sys, .rst, .txValid, .txData, .txLast, .txReady, .slow, .clr);

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Pulses stand one cycle, so they are counted mid-cycle
	always @(negedge clk_sys)
	begin
		if (fieldValid)
		begin
			fvCnt++;
			lastKind = fieldKind;
			lastIdx = fieldIndex;
			lastData = fieldData;
		end
		if (duplicateDrop)
			dupCnt++;
		if (keyUpdate)
			keyCnt++;
		if (nvWrite)
			nvCnt++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic fill(input logic [7:0] fl);
		for (int i = 0; i < 206; i++)
			req[i] = (i < 4) ? 8'h00 : (i == 4) ? fl : (i == 5) ? 8'ha5 : 8'(i);
	endtask

	task automatic send(input logic [1:0] typ, input int len);
		int n;
		@(negedge clk_sys);
		clr = 1'b1;
		@(negedge clk_sys);
		clr = 1'b0;
		for (int i = 0; i < len; i++)
		begin
			rxValid = 1'b1;
			rxFirst = (i == 0);
			rxType = typ;
			rxData = req[i];
			n = 0;
			while (!rxReady && n < 50)
			begin
				@(negedge clk_sys);
				n++;
			end
			if (n == 50)
			begin
				bad_count++;
				complete_run();
			end
			@(negedge clk_sys);
		end
		rxValid = 1'b0;
		rxFirst = 1'b0;
	endtask

	task automatic wait_rsp(input int len);
		int n;
		n = 0;
		while (i_net.lastPos < 0 && n < 2000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 2000)
		begin
			bad_count++;
			complete_run();
		end
		chk("rsp count", i_net.count, len);
		chk("txLast pos", i_net.lastPos, len - 1);
	endtask

	function automatic logic [7:0] rspByte(input int i, input logic [7:0] fl, input logic [7:0] ctr);
		if (i < 4)
			return 8'h00;
		if (i == 4)
			return fl;
		if (i == 5)
			return ctr;
		if (i < 14)
			return {2'b01, 6'(i - 6)};
		if (i < 34)
			return {2'b10, 6'(i - 14)};
		return {2'b11, 6'(i - 34)};
	endfunction

	task automatic key_xchg(input logic [1:0] typ, input logic [7:0] fl, input logic [7:0] eFl,
		input logic [7:0] eCtr);
		int len;
		len = (typ == 2'd1) ? 98 : 34;
		fill(fl);
		k0 = keyCnt;
		send(typ, (typ == 2'd1) ? 206 : 14);
		wait_rsp(len);
		for (int i = 0; i < len; i++)
			chk("rsp byte", i_net.rsp[i], rspByte(i, eFl, eCtr));
		chk("keyUpdate", keyCnt - k0, 1);
		chk("keySlot", keySlot, fl[0]);
	endtask

	task automatic confirm;
		k0 = nvCnt;
		@(negedge clk_sys);
		connectConfirm = 1'b1;
		@(negedge clk_sys);
		connectConfirm = 1'b0;
		@(negedge clk_sys);
		chk("nvWrite", nvCnt - k0, 1);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rxValid, rxFirst, rxType, rxData, nvLoad, connectConfirm, slow, clr} = '0;
		{capPubKey, capHash, capCipher, capNonce} = 5'b11111;
		newCookie = 160'hc0ffee;
		nvCookie = 160'h1234;
		nvCookieSeq = 1'b0;
		nvCounter = 8'hfe;
		nvCounterSeq = 1'b1;
		{bad_count, comparisons, fvCnt, dupCnt, keyCnt, nvCnt} = '0;
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		nvLoad = 1'b1;
		@(negedge clk_sys);
		nvLoad = 1'b0;
		// Sign-on: mixed offers, a long-key offer with only the short key supported, then a short-key offer
		for (int c = 0; c < 3; c++)
		begin
			{capPubKey, capHash, capCipher, capNonce} = caps[c];
			for (int i = 0; i < 8; i++)
				req[i] = (i < 4) ? offers[c][31 - 8 * i -: 8] : 8'h00;
			send(2'd0, 8);
			wait_rsp(8);
			for (int i = 0; i < 8; i++)
				chk("signon", i_net.rsp[i],
					(i < 4) ? picks[c][31 - 8 * i -: 8] : 8'h00);
		end
		key_xchg(2'd2, 8'h03, 8'h00, 8'hff);
		chk("committed ctr", {counterSeq, cloneCounter}, 9'h1fe);
		k0 = dupCnt;
		send(2'd2, 14);
		repeat (40) @(negedge clk_sys);
		chk("dup rsp", i_net.count, 0);
		chk("dup drop", dupCnt - k0, 1);
		confirm();
		chk("commit ctr", {counterSeq, cloneCounter}, 9'h0ff);
		slow = 1'b1;
		key_xchg(2'd2, 8'h06, 8'h01, 8'h00);
		confirm();
		chk("commit wrap", {cookieSeq, counterSeq, cloneCounter}, 10'h100);
		f0 = fvCnt;
		key_xchg(2'd1, 8'h0e, 8'h03, 8'h01);
		chk("field count", fvCnt - f0, 200);
		chk("last field", {lastKind, lastIdx}, {2'd3, 8'd63});
		chk("last data", lastData, 8'hcd);
		chk("cookie held", cookie[31:0], 32'h00001234);
		chk("auth cookie", authCookie === newCookie, 1);
		chk("first flag", firstExchange, 1);
		chk("pending held", {cookieSeq, cloneCounter}, 9'h000);
		slow = 1'b0;
		key_xchg(2'd2, 8'h00, 8'h01, 8'h00);
		chk("restart cookie", authCookie === nvCookie, 1);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire

// file: dv/tkx_ncc_model.sv
// Network-side model that takes response bytes, optionally stalling
`timescale 1ns/10ps
`default_nettype none
module tkx_net_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Response stream
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txLast,
	output logic txReady,
	// Bench control
	input wire logic slow,
	input wire logic clr
);
	logic [7:0] rsp [0:127];
	int count;
	int lastPos;
	logic phase;
	// Bytes are collected as sent; the bench compares every byte, the authenticator too
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			phase <= 1'b0;
			count <= 0;
			lastPos <= -1;
		end
		else
		begin
			phase <= ~phase;
			if (clr)
			begin
				count <= 0;
				lastPos <= -1;
			end
			else if (txValid && txReady)
			begin
				rsp[count[6:0]] <= txData;
				count <= count + 1;
				if (txLast)
					lastPos <= count;
			end
		end
	end
	// Slow mode accepts only every other cycle
	assign txReady = !slow || phase;
endmodule // tkx_net_model
`default_nettype wire

// file: src/tkx_key_exchange.sv
// Terminal-side security sign-on and key-exchange message handler
`timescale 1ns/10ps
`default_nettype none
`include "tkx_map.svh"
module tkx_key_exchange import tkx_pkg::*; #(
	parameter int COOKIE_W = 160
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Request byte stream
	input wire logic rxValid,
	input wire logic rxFirst,
	input wire logic [1:0] rxType,
	input wire logic [7:0] rxData,
	output logic rxReady,
	// Parsed request fields
	output logic fieldValid,
	output logic [1:0] fieldKind,
	output logic [7:0] fieldIndex,
	output logic [7:0] fieldData,
	// Supported options
	input wire logic capPubKey,
	input wire logic capHash,
	input wire logic [1:0] capCipher,
	input wire logic capNonce,
	// Crypto engine
	output logic [1:0] cryptoKind,
	output logic [7:0] cryptoIndex,
	input wire logic [7:0] cryptoByte,
	input wire logic [COOKIE_W-1:0] newCookie,
	output logic [COOKIE_W-1:0] authCookie,
	output logic keyUpdate,
	output logic keySlot,
	output logic firstExchange,
	output logic duplicateDrop,
	// Response byte stream
	output logic txValid,
	output logic [7:0] txData,
	output logic txLast,
	input wire logic txReady,
	// Persistent storage
	input wire logic nvLoad,
	input wire logic [COOKIE_W-1:0] nvCookie,
	input wire logic nvCookieSeq,
	input wire logic [7:0] nvCounter,
	input wire logic nvCounterSeq,
	input wire logic connectConfirm,
	output logic nvWrite,
	output logic [COOKIE_W-1:0] cookie,
	output logic cookieSeq,
	output logic [7:0] cloneCounter,
	output logic counterSeq
);
	// ----------------------------------------------------------------
	// Request intake
	// ----------------------------------------------------------------
	tkx_state_t state_reg, state_next;
	tkx_msg_t type_reg, type_next, curType;
	logic [7:0] pos_reg, pos_next, curPos, reqLen;
	logic [7:0] hash_reg, hash_next, curHash;
	logic [7:0] lastHash_reg, lastHash_next;
	tkx_msg_t lastType_reg, lastType_next;
	logic lastValid_reg, lastValid_next;
	logic [7:0] offer_reg [4];
	logic [7:0] offer_next [4];
	logic [3:0] flags_reg, flags_next;
	logic [7:0] txCount_reg, txCount_next, txLen, txPos_reg, txPos_next;
	logic txValid_next, txLast_next, load, take, reqDone, dup, newReq;
	logic [7:0] txData_next, txByte, choice [4];
	logic fieldValid_next;
	logic [1:0] fieldKind_next;
	logic [7:0] fieldIndex_next;
	logic keyUpdate_next, dupDrop_next;
	// Persistent state: committed and pending copies
	logic [COOKIE_W-1:0] pendCookie_reg, pendCookie_next, cookie_next;
	logic pendCookieSeq_reg, pendCookieSeq_next, cookieSeq_next;
	logic [7:0] pendCounter_reg, pendCounter_next, counter_next;
	logic pendCounterSeq_reg, pendCounterSeq_next, counterSeq_next;
	logic dirty_reg, dirty_next, nvWrite_next;
	logic [7:0] baseCounter;
	logic baseCounterSeq;

	assign rxReady = (state_reg != TKX_SEND);
	assign curType = rxFirst ? tkx_msg_t'(rxType) : type_reg;
	assign curPos = rxFirst ? 8'h00 : pos_reg;
	assign curHash = rxFirst ? rxData : ({hash_reg[6:0], hash_reg[7]} ^ rxData);
	assign take = rxValid && rxReady && (rxFirst || state_reg == TKX_RECV);
	assign reqLen = (curType == TKX_MAIN) ? `TKX_MAIN_REQ_LEN :
		(curType == TKX_QUICK) ? `TKX_QUICK_REQ_LEN : `TKX_SIGNON_LEN;
	assign reqDone = take && (curPos == reqLen - 8'd1);
	assign dup = lastValid_reg && (curHash == lastHash_reg) && (curType == lastType_reg); // R22
	assign newReq = reqDone && !dup && (curType != TKX_SIGNON);
	assign load = !txValid || txReady;

	// ----------------------------------------------------------------
	// Sign-on choice, long cipher key preferred
	// ----------------------------------------------------------------
	assign choice[0] = {7'h00, offer_reg[0][`TKX_PKA_BIT] & capPubKey}; // R1 R4
	assign choice[1] = {7'h00, offer_reg[1][`TKX_HASH_BIT] & capHash}; // R1 R4
	assign choice[2] = (offer_reg[2][`TKX_EA_LONG_BIT] & capCipher[1]) ? 8'h02 :
		(offer_reg[2][`TKX_EA_SHORT_BIT] & capCipher[0]) ? 8'h01 : 8'h00; // R1 R2 R5
	assign choice[3] = {7'h00, offer_reg[3][`TKX_NONCE_BIT] & capNonce}; // R1 R4

	// ----------------------------------------------------------------
	// Response byte source
	// ----------------------------------------------------------------
	assign txLen = (type_reg == TKX_MAIN) ? `TKX_MAIN_RSP_LEN :
		(type_reg == TKX_QUICK) ? `TKX_QUICK_RSP_LEN : `TKX_SIGNON_LEN;
	always_comb
	begin
		cryptoKind = TKX_C_NONE;
		cryptoIndex = 8'h00;
		txByte = 8'h00; // R7 R8
		if (type_reg == TKX_SIGNON)
		begin
			if (txCount_reg < 8'd4)
				txByte = choice[txCount_reg[1:0]];
		end
		else if (txCount_reg == `TKX_ID_LEN)
			txByte = {6'h00, pendCookieSeq_reg, pendCounterSeq_reg}; // R15 R16 R17
		else if (txCount_reg == `TKX_ID_LEN + 8'd1)
			txByte = pendCounter_reg; // R17
		else if (txCount_reg >= 8'd6 && txCount_reg < 8'd6 + `TKX_PNS)
		begin
			cryptoKind = TKX_C_NONCE; // R15
			cryptoIndex = txCount_reg - 8'd6;
			txByte = cryptoByte;
		end
		else if (txCount_reg >= 8'd14 && txCount_reg < 8'd14 + `TKX_PHA)
		begin
			cryptoKind = TKX_C_AUTH; // R6 R15
			cryptoIndex = txCount_reg - 8'd14;
			txByte = cryptoByte;
		end
		else if (txCount_reg >= 8'd34)
		begin
			cryptoKind = TKX_C_PUB; // R6 R15
			cryptoIndex = txCount_reg - 8'd34;
			txByte = cryptoByte;
		end
	end

	// ----------------------------------------------------------------
	// Control next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		type_next = type_reg;
		pos_next = pos_reg;
		hash_next = hash_reg;
		lastHash_next = lastHash_reg;
		lastType_next = lastType_reg;
		lastValid_next = lastValid_reg && !connectConfirm;
		for (int i = 0; i < 4; i++)
			offer_next[i] = offer_reg[i];
		flags_next = flags_reg;
		fieldValid_next = 1'b0;
		fieldKind_next = fieldKind;
		fieldIndex_next = fieldIndex;
		keyUpdate_next = 1'b0;
		dupDrop_next = 1'b0;
		txCount_next = txCount_reg;
		txPos_next = txPos_reg;
		txValid_next = txValid && !txReady;
		txLast_next = txLast;
		txData_next = txData;
		if (take)
		begin
			type_next = curType;
			pos_next = curPos + 8'd1;
			hash_next = curHash;
			state_next = TKX_RECV;
			if (curType == TKX_SIGNON && curPos < 8'd4)
				offer_next[curPos[1:0]] = rxData;
			if (curPos == `TKX_ID_LEN && curType != TKX_SIGNON)
				flags_next = (curType == TKX_MAIN) ? rxData[3:0] : {2'b00, rxData[1:0]}; // R9 R20 R24
			if (curType != TKX_SIGNON && curPos >= 8'd6)
			begin
				fieldValid_next = 1'b1; // R10
				if (curPos < 8'd14)
				begin
					fieldKind_next = TKX_F_NONCE;
					fieldIndex_next = curPos - 8'd6;
				end
				else if (curPos < 8'd78)
				begin
					fieldKind_next = TKX_F_MOD;
					fieldIndex_next = curPos - 8'd14;
				end
				else if (curPos < 8'd142)
				begin
					fieldKind_next = TKX_F_GEN;
					fieldIndex_next = curPos - 8'd78;
				end
				else
				begin
					fieldKind_next = TKX_F_PUB;
					fieldIndex_next = curPos - 8'd142;
				end
			end
			if (reqDone)
			begin
				lastHash_next = curHash;
				lastType_next = curType;
				lastValid_next = 1'b1;
				txCount_next = 8'h00;
				state_next = dup ? TKX_IDLE : TKX_SEND;
				dupDrop_next = dup; // R22
				keyUpdate_next = newReq; // R11 R19
			end
		end
		if (state_reg == TKX_SEND && load)
		begin
			if (txCount_reg < txLen)
			begin
				txValid_next = 1'b1;
				txData_next = txByte;
				txPos_next = txCount_reg;
				txLast_next = (txCount_reg == txLen - 8'd1);
				txCount_next = txCount_reg + 8'd1;
			end
			else
				state_next = TKX_IDLE;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= TKX_IDLE;
			type_reg <= TKX_SIGNON;
			pos_reg <= 8'h00;
			hash_reg <= 8'h00;
			lastHash_reg <= 8'h00;
			lastType_reg <= TKX_SIGNON;
			lastValid_reg <= 1'b0;
			for (int i = 0; i < 4; i++)
				offer_reg[i] <= 8'h00;
			flags_reg <= 4'h0;
			fieldValid <= 1'b0;
			fieldKind <= 2'b00;
			fieldIndex <= 8'h00;
			fieldData <= 8'h00;
			keyUpdate <= 1'b0;
			duplicateDrop <= 1'b0;
			txCount_reg <= 8'h00;
			txPos_reg <= 8'h00;
			txValid <= 1'b0;
			txLast <= 1'b0;
			txData <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			type_reg <= type_next;
			pos_reg <= pos_next;
			hash_reg <= hash_next;
			lastHash_reg <= lastHash_next;
			lastType_reg <= lastType_next;
			lastValid_reg <= lastValid_next;
			for (int i = 0; i < 4; i++)
				offer_reg[i] <= offer_next[i];
			flags_reg <= flags_next;
			fieldValid <= fieldValid_next;
			fieldKind <= fieldKind_next;
			fieldIndex <= fieldIndex_next;
			fieldData <= take ? rxData : fieldData;
			keyUpdate <= keyUpdate_next;
			duplicateDrop <= dupDrop_next;
			txCount_reg <= txCount_next;
			txPos_reg <= txPos_next;
			txValid <= txValid_next;
			txLast <= txLast_next;
			txData <= txData_next;
		end
	end

	assign keySlot = flags_reg[`TKX_FL_SLOT]; // R11
	assign firstExchange = flags_reg[`TKX_FL_FIRST];
	assign authCookie = pendCookie_reg; // R16

	// ----------------------------------------------------------------
	// Cookie and clone counter, pending until confirmed
	// ----------------------------------------------------------------
	always_comb
	begin
		cookie_next = cookie;
		cookieSeq_next = cookieSeq;
		counter_next = cloneCounter;
		counterSeq_next = counterSeq;
		pendCookie_next = pendCookie_reg;
		pendCookieSeq_next = pendCookieSeq_reg;
		pendCounter_next = pendCounter_reg;
		pendCounterSeq_next = pendCounterSeq_reg;
		dirty_next = dirty_reg;
		nvWrite_next = 1'b0;
		baseCounter = cloneCounter;
		baseCounterSeq = counterSeq;
		if (nvLoad)
		begin
			cookie_next = nvCookie; // R21
			cookieSeq_next = nvCookieSeq;
			counter_next = nvCounter;
			counterSeq_next = nvCounterSeq;
			pendCookie_next = nvCookie;
			pendCookieSeq_next = nvCookieSeq;
			pendCounter_next = nvCounter;
			pendCounterSeq_next = nvCounterSeq;
			dirty_next = 1'b0;
		end
		else if (newReq)
		begin
			pendCookie_next = cookie; // R23
			pendCookieSeq_next = cookieSeq;
			dirty_next = 1'b0;
			if (curType == TKX_MAIN && flags_reg[`TKX_FL_COOKIE])
			begin
				pendCookie_next = newCookie; // R13 R19
				pendCookieSeq_next = !cookieSeq;
				baseCounter = `TKX_COUNTER_RST;
				baseCounterSeq = `TKX_SEQ_RST;
				dirty_next = 1'b1;
			end
			pendCounter_next = baseCounter;
			pendCounterSeq_next = baseCounterSeq;
			if (flags_reg[`TKX_FL_COUNT])
			begin
				pendCounter_next = baseCounter + 8'd1; // R12
				pendCounterSeq_next = !baseCounterSeq;
				dirty_next = 1'b1;
			end
		end
		else if (connectConfirm && dirty_reg)
		begin
			cookie_next = pendCookie_reg; // R18
			cookieSeq_next = pendCookieSeq_reg;
			counter_next = pendCounter_reg;
			counterSeq_next = pendCounterSeq_reg;
			dirty_next = 1'b0;
			nvWrite_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cookie <= '0;
			cookieSeq <= `TKX_SEQ_RST;
			cloneCounter <= `TKX_COUNTER_RST;
			counterSeq <= `TKX_SEQ_RST;
			pendCookie_reg <= '0;
			pendCookieSeq_reg <= `TKX_SEQ_RST;
			pendCounter_reg <= `TKX_COUNTER_RST;
			pendCounterSeq_reg <= `TKX_SEQ_RST;
			dirty_reg <= 1'b0;
			nvWrite <= 1'b0;
		end
		else
		begin
			cookie <= cookie_next;
			cookieSeq <= cookieSeq_next;
			cloneCounter <= counter_next;
			counterSeq <= counterSeq_next;
			pendCookie_reg <= pendCookie_next;
			pendCookieSeq_reg <= pendCookieSeq_next;
			pendCounter_reg <= pendCounter_next;
			pendCounterSeq_reg <= pendCounterSeq_next;
			dirty_reg <= dirty_next;
			nvWrite <= nvWrite_next;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_CHOICE_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst) // R1
		$onehot0(choice[2]) && choice[0][7:1] == 7'h00 && choice[3][7:1] == 7'h00)
		else $error("class choice not one-hot");
	AST_CHOICE_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // R2
		(offer_reg[2][1:0] & capCipher) == 2'b00 |-> choice[2] == 8'h00)
		else $error("unsupported cipher class not zero");
	AST_ID_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // R8
		txValid && type_reg != TKX_SIGNON && txPos_reg < 8'd4 |-> txData == 8'h00)
		else $error("link identifier byte not zero");
	AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // R7
		txValid && type_reg == TKX_SIGNON && txPos_reg >= 8'd4 |-> txData == 8'h00)
		else $error("reserved sign-on byte not zero");
	AST_FLAG_BYTE: assert property (@(posedge clk_sys) disable iff (rst) // R15
		txValid && type_reg != TKX_SIGNON && txPos_reg == 8'd4
		|-> txData == {6'h00, pendCookieSeq_reg, pendCounterSeq_reg})
		else $error("response flag byte wrong");
	AST_LEN_MAIN: assert property (@(posedge clk_sys) disable iff (rst) // R6
		txValid && txLast && type_reg == TKX_MAIN |-> txPos_reg == 8'd97)
		else $error("main response length wrong");
	AST_COUNT_INC: assert property (@(posedge clk_sys) disable iff (rst) // R12
		newReq && !nvLoad && flags_reg[1] && !(curType == TKX_MAIN && flags_reg[2])
		|=> pendCounter_reg == $past(cloneCounter) + 8'd1 && pendCounterSeq_reg != $past(counterSeq))
		else $error("counter increment wrong");
	AST_NEW_COOKIE: assert property (@(posedge clk_sys) disable iff (rst) // R13
		newReq && !nvLoad && curType == TKX_MAIN && flags_reg[2]
		|=> pendCookieSeq_reg != $past(cookieSeq)
		&& pendCounter_reg == {7'h00, $past(flags_reg[1])}
		&& pendCounterSeq_reg == $past(flags_reg[1]))
		else $error("new cookie update wrong");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R18
		!connectConfirm && !nvLoad |=> $stable(cookieSeq) && $stable(cloneCounter))
		else $error("committed state changed without confirm");
	AST_DUP: assert property (@(posedge clk_sys) disable iff (rst) // R22
		reqDone && dup |=> state_reg == TKX_IDLE ##1 !txValid)
		else $error("duplicate request answered");
endmodule // tkx_key_exchange
`default_nettype wire

// file: src/tkx_map.svh
// Field positions, lengths and reset values of the key-exchange handler
`ifndef TKX_MAP_SVH
`define TKX_MAP_SVH
// Functional notes
// [R1] Sign-on answer: one offered bit per class
// [R2] No supported offer gives zero class byte
// [R3] Network falls back or re-offers on zero
// [R4] Key, hash, nonce choice in bit 0
// [R5] Cipher: bit 1 long key, bit 0 short
// [R6] Lengths: 64 public, 20 auth, 8 key, 8 nonce
// [R7] Reserved trailing fields sent as zero
// [R8] Link identifier always four zero bytes
// [R9] Request flags: first, new cookie, increment, slot
// [R10] Parse nonce, modulus, generator, public value
// [R11] Slot bit picks session-key slot updated
// [R12] Increment flag: counter plus one, toggle seq
// [R13] New cookie: toggle seq, zero counter state
// [R14] Network ignores authenticator on first exchange
// [R15] Response: id, flags, counter, nonce, auth, public
// [R16] Cookie seq is that of authenticating cookie
// [R17] Counter and its seq report current state
// [R18] Updates stay pending until connect confirm
// [R19] New key and cookie from own exponent
// [R20] Quick request: two flags, never touches cookie
// [R21] Persistent cookie, counter and sequence bits
// [R22] Drop duplicate copies of a request
// [R23] New request restarts from committed state
// [R24] Reserved request bits are ignored
`define TKX_PKA_BIT 0
`define TKX_HASH_BIT 0
`define TKX_NONCE_BIT 0
`define TKX_EA_LONG_BIT 1
`define TKX_EA_SHORT_BIT 0
`define TKX_PUB_LEN 8'd64
`define TKX_PHA 8'd20
`define TKX_PEA 8'd8
`define TKX_PNS 8'd8
`define TKX_ID_LEN 8'd4
`define TKX_FL_FIRST 3
`define TKX_FL_COOKIE 2
`define TKX_FL_COUNT 1
`define TKX_FL_SLOT 0
`define TKX_SIGNON_LEN 8'd8
`define TKX_MAIN_REQ_LEN 8'd206
`define TKX_QUICK_REQ_LEN 8'd14
`define TKX_MAIN_RSP_LEN 8'd98
`define TKX_QUICK_RSP_LEN 8'd34
`define TKX_COUNTER_RST 8'h00
`define TKX_SEQ_RST 1'b0
`endif

// file: src/tkx_pkg.sv
// Types shared by the key-exchange handler
package tkx_pkg;
	typedef enum logic [1:0] {TKX_IDLE = 2'b00, TKX_RECV = 2'b01, TKX_SEND = 2'b10} tkx_state_t;
	typedef enum logic [1:0] {TKX_SIGNON = 2'b00, TKX_MAIN = 2'b01, TKX_QUICK = 2'b10} tkx_msg_t;
	typedef enum logic [1:0] {TKX_F_NONCE = 2'b00, TKX_F_MOD = 2'b01, TKX_F_GEN = 2'b10,
		TKX_F_PUB = 2'b11} tkx_field_t;
	typedef enum logic [1:0] {TKX_C_NONE = 2'b00, TKX_C_NONCE = 2'b01, TKX_C_AUTH = 2'b10,
		TKX_C_PUB = 2'b11} tkx_src_t;
endpackage
